// *** design/io_line_mux_controller.sv ***
`timescale 1ns/1ns
module io_line_mux_controller
  import io_mux_pkg::*;
#(
  parameter int LINES = NUM_LINES
) (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic [31:0]             prdata,
  // peripheral functions
  input  wire periph_drive_t      periph_a,
  input  wire periph_drive_t      periph_b,
  output logic [31:0]             periph_in,
  output logic                    fast_irq_input,
  output logic                    ext_irq_input_0,
  output logic                    ext_irq_input_1,
  output logic [3:0]              analog_sel,
  // pads
  input  wire logic [31:0]        pad_in,
  output pad_drive_t              pad,
  // interrupt
  output logic                    irq
);
  logic [31:0] func_reg, oe_reg, filt_reg, data_reg, imask_reg, istat_reg;
  logic [31:0] md_reg, pu_reg, selb_reg, sync_reg;
  logic [31:0] sync1_reg, sync2_reg, prev_reg, filt_q_reg, level;
  logic        wr, rd, acc, rd_clr;
  logic [31:0] rdata;
  logic        mapped;
  periph_drive_t sel_drv;
  logic [31:0] drv_o, drv_oe;

  assign acc = psel & penable;
  assign wr  = acc & pwrite;
  assign rd  = acc & ~pwrite;
  // a status read clears only the bits it returned
  assign rd_clr = rd && paddr == OFF_IRQ_STAT;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_reg <= RST_ALL_ONES;
    end else if (wr && paddr == OFF_FUNC_EN) begin
      func_reg <= func_reg | pwdata;
    end else if (wr && paddr == OFF_FUNC_DIS) begin
      func_reg <= func_reg & ~pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_reg <= RST_ZERO;
    end else if (wr && paddr == OFF_OUT_EN) begin
      oe_reg <= oe_reg | pwdata;
    end else if (wr && paddr == OFF_OUT_DIS) begin
      oe_reg <= oe_reg & ~pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_reg <= RST_ZERO;
    end else if (wr && paddr == OFF_FILT_EN) begin
      filt_reg <= filt_reg | pwdata;
    end else if (wr && paddr == OFF_FILT_DIS) begin
      filt_reg <= filt_reg & ~pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_reg <= RST_ZERO;
    end else if (wr && paddr == OFF_IRQ_EN) begin
      imask_reg <= imask_reg | pwdata;
    end else if (wr && paddr == OFF_IRQ_DIS) begin
      imask_reg <= imask_reg & ~pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      md_reg <= RST_ZERO;
    end else if (wr && paddr == OFF_MD_EN) begin
      md_reg <= md_reg | pwdata;
    end else if (wr && paddr == OFF_MD_DIS) begin
      md_reg <= md_reg & ~pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pu_reg <= RST_ALL_ONES;
    end else if (wr && paddr == OFF_PU_EN) begin
      pu_reg <= pu_reg | pwdata;
    end else if (wr && paddr == OFF_PU_DIS) begin
      pu_reg <= pu_reg & ~pwdata;
    end
  end

  // peripheral select
  // select b sets the bit, select a clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      selb_reg <= RST_ZERO;
    end else if (wr && paddr == OFF_SEL_B) begin
      selb_reg <= selb_reg | pwdata;
    end else if (wr && paddr == OFF_SEL_A) begin
      selb_reg <= selb_reg & ~pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_reg <= RST_ZERO;
    end else if (wr && paddr == OFF_SYNC_EN) begin
      sync_reg <= sync_reg | pwdata;
    end else if (wr && paddr == OFF_SYNC_DIS) begin
      sync_reg <= sync_reg & ~pwdata;
    end
  end

  // output data latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_reg <= RST_ZERO;
    end else if (wr && paddr == OFF_SET_DATA) begin
      data_reg <= data_reg | pwdata;
    end else if (wr && paddr == OFF_CLR_DATA) begin
      data_reg <= data_reg & ~pwdata;
    end else if (wr && paddr == OFF_SYNC_DATA) begin
      // one-write update
      // sync data touches only lines enabled for it
      data_reg <= (data_reg & ~sync_reg) | (pwdata & sync_reg);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // pins idle high under the reset pull-ups
      sync1_reg <= RST_ALL_ONES;
      sync2_reg <= RST_ALL_ONES;
    end else begin
      sync1_reg <= pad_in;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_q_reg <= RST_ALL_ONES;
    end else begin
      filt_q_reg <= sync2_reg;
    end
  end

  // filtered lines need two equal samples to change
  generate
    for (genvar i = 0; i < LINES; i++) begin : g_lvl
      assign level[i] = (filt_reg[i] && sync2_reg[i] != filt_q_reg[i]) ?
                        prev_reg[i] : sync2_reg[i];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg  <= RST_ALL_ONES;
      istat_reg <= RST_ZERO;
    end else begin
      prev_reg <= level;
      istat_reg <= ((rd_clr ? ~prdata : RST_ALL_ONES) & istat_reg)
                   | (level ^ prev_reg);
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_LINES; i++) begin
      sel_drv.o[i]  = selb_reg[i] ? periph_b.o[i]  : periph_a.o[i];
      sel_drv.oe[i] = selb_reg[i] ? periph_b.oe[i] : periph_a.oe[i];
    end
    drv_o  = (func_reg & data_reg) | (~func_reg & sel_drv.o);
    drv_oe = (func_reg & oe_reg)   | (~func_reg & sel_drv.oe);
  end

  always_comb begin
    mapped = 1'b1;
    rdata  = RST_ZERO;
    unique case (paddr)
      OFF_FUNC_STAT: rdata = func_reg;
      OFF_OUT_STAT:  rdata = oe_reg;
      OFF_FILT_STAT: rdata = filt_reg;
      OFF_DATA_STAT: rdata = data_reg;
      OFF_PIN_STAT:  rdata = level;
      OFF_IRQ_MASK:  rdata = imask_reg;
      OFF_IRQ_STAT:  rdata = istat_reg;
      OFF_MD_STAT:   rdata = md_reg;
      OFF_PU_STAT:   rdata = ~pu_reg;
      OFF_SEL_STAT:  rdata = selb_reg;
      OFF_SYNC_STAT: rdata = sync_reg;
      OFF_FUNC_EN, OFF_FUNC_DIS, OFF_OUT_EN, OFF_OUT_DIS, OFF_FILT_EN,
      OFF_FILT_DIS, OFF_SET_DATA, OFF_CLR_DATA, OFF_IRQ_EN, OFF_IRQ_DIS,
      OFF_MD_EN, OFF_MD_DIS, OFF_PU_EN, OFF_PU_DIS, OFF_SEL_A, OFF_SEL_B,
      OFF_SYNC_EN, OFF_SYNC_DIS, OFF_SYNC_DATA: rdata = RST_ZERO;
      default: mapped = 1'b0;
    endcase
  end

  // apb answer, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= RST_ZERO;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? rdata : RST_ZERO;
    end
  end

  // pad and peripheral outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad       <= '{o: RST_ZERO, oe: RST_ZERO, pu: RST_ALL_ONES};
      periph_in <= RST_ZERO;
    end else begin
      pad.o  <= drv_o & ~md_reg;
      pad.oe <= drv_oe & ~(md_reg & drv_o);
      pad.pu <= pu_reg;
      periph_in <= level;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_irq_input  <= 1'b0;
      ext_irq_input_0 <= 1'b0;
      ext_irq_input_1 <= 1'b0;
      analog_sel      <= 4'h0;
    end else begin
      // each input reads its pin only while its function is chosen
      fast_irq_input  <= ~func_reg[LINE_FAST_IRQ] & selb_reg[LINE_FAST_IRQ] &
                         level[LINE_FAST_IRQ];
      ext_irq_input_0 <= ~func_reg[LINE_IRQ_0] & selb_reg[LINE_IRQ_0] &
                         level[LINE_IRQ_0];
      ext_irq_input_1 <= ~func_reg[LINE_IRQ_1] & ~selb_reg[LINE_IRQ_1] &
                         level[LINE_IRQ_1];
      // analog lines 17-20
      // analog only when general, output off and pull-up off
      analog_sel <= ~oe_reg[LINE_AN_LO +: 4] & func_reg[LINE_AN_LO +: 4] &
                    ~pu_reg[LINE_AN_LO +: 4];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat_reg & imask_reg);
    end
  end
endmodule // io_line_mux_controller

// *** design/io_mux_pkg.sv ***
package io_mux_pkg;
  localparam int NUM_LINES = 32;
  // register byte offsets
  localparam logic [7:0] OFF_FUNC_EN   = 8'h00;
  localparam logic [7:0] OFF_FUNC_DIS  = 8'h04;
  localparam logic [7:0] OFF_FUNC_STAT = 8'h08;
  localparam logic [7:0] OFF_OUT_EN    = 8'h10;
  localparam logic [7:0] OFF_OUT_DIS   = 8'h14;
  localparam logic [7:0] OFF_OUT_STAT  = 8'h18;
  localparam logic [7:0] OFF_FILT_EN   = 8'h20;
  localparam logic [7:0] OFF_FILT_DIS  = 8'h24;
  localparam logic [7:0] OFF_FILT_STAT = 8'h28;
  localparam logic [7:0] OFF_SET_DATA  = 8'h30;
  localparam logic [7:0] OFF_CLR_DATA  = 8'h34;
  localparam logic [7:0] OFF_DATA_STAT = 8'h38;
  localparam logic [7:0] OFF_PIN_STAT  = 8'h3C;
  localparam logic [7:0] OFF_IRQ_EN    = 8'h40;
  localparam logic [7:0] OFF_IRQ_DIS   = 8'h44;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h48;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h4C;
  localparam logic [7:0] OFF_MD_EN     = 8'h50;
  localparam logic [7:0] OFF_MD_DIS    = 8'h54;
  localparam logic [7:0] OFF_MD_STAT   = 8'h58;
  localparam logic [7:0] OFF_PU_DIS    = 8'h60;
  localparam logic [7:0] OFF_PU_EN     = 8'h64;
  localparam logic [7:0] OFF_PU_STAT   = 8'h68;
  localparam logic [7:0] OFF_SEL_A     = 8'h70;
  localparam logic [7:0] OFF_SEL_B     = 8'h74;
  localparam logic [7:0] OFF_SEL_STAT  = 8'h78;
  localparam logic [7:0] OFF_SYNC_EN   = 8'hA0;
  localparam logic [7:0] OFF_SYNC_DIS  = 8'hA4;
  localparam logic [7:0] OFF_SYNC_STAT = 8'hA8;
  localparam logic [7:0] OFF_SYNC_DATA = 8'hAC;
  // reset values
  localparam logic [31:0] RST_ALL_ONES = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
  // fixed map positions
  localparam int LINE_FAST_IRQ = 19;
  localparam int LINE_IRQ_0    = 20;
  localparam int LINE_IRQ_1    = 30;
  localparam int LINE_AN_LO    = 17;

  typedef struct packed {
    logic [31:0] o;
    logic [31:0] oe;
  } periph_drive_t;

  typedef struct packed {
    logic [31:0] o;
    logic [31:0] oe;
    logic [31:0] pu;
  } pad_drive_t;
endpackage

// *** bench/board_model.sv ***
`timescale 1ns/1ns
module board_model
  import io_mux_pkg::*;
(
  // device pads
  input  wire pad_drive_t  pad,
  output logic [31:0]      pad_in,
  // board level on released lines
  input  wire logic [31:0] ext_val
);
  assign pad_in = (pad.oe & pad.o) | (~pad.oe & ext_val);
endmodule // board_model

// *** bench/io_line_mux_controller_chk.sv ***
`timescale 1ns/1ns
module io_line_mux_controller_chk
  import io_mux_pkg::*;
(
  // bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // lines
  input wire logic [31:0] periph_in,
  input wire logic        fast_irq_input,
  input wire logic        ext_irq_input_0,
  input wire logic        ext_irq_input_1,
  input wire logic [3:0]  analog_sel,
  input wire logic [31:0] pad_in,
  input wire pad_drive_t  pad,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] up_cnt;
  // cycles since reset, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up_cnt <= 3'h0;
    else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
  end
  sequence quiet_s;
    (up_cnt == 3'h7 && $stable(pad_in)) [*5];
  endsequence
  chk_reset_state: assert property (
    !$past(presetn) |-> pad.pu == RST_ALL_ONES && pad.oe == RST_ZERO && !irq)
    else $error("pads not in reset state");
  chk_setup_ready: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  chk_rdata_idle: assert property (!pready |-> prdata == RST_ZERO)
    else $error("prdata not zero");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_analog_safe: assert property (
    (analog_sel & (pad.pu[20:17] | pad.oe[20:17])) == 4'h0)
    else $error("analog line driven or pulled");
  chk_pin_follow: assert property (quiet_s |-> periph_in == pad_in)
    else $error("periph_in lags pins");
  chk_fixed_map: assert property (quiet_s |-> ({fast_irq_input,
    ext_irq_input_0, ext_irq_input_1} & ~{pad_in[19], pad_in[20], pad_in[30]}) == 3'h0)
    else $error("irq input without pin level");
  cover property (irq);
  cover property (pslverr);
  cover property (fast_irq_input);
  cover property (analog_sel == 4'hF);
endmodule // io_line_mux_controller_chk

bind io_line_mux_controller io_line_mux_controller_chk chk_inst (.pclk, .presetn, .psel,
  .penable, .pready, .pslverr, .prdata, .periph_in, .fast_irq_input, .ext_irq_input_0,
  .ext_irq_input_1, .analog_sel, .pad_in, .pad, .irq);

// *** bench/test_io_line_mux_controller.sv ***
`timescale 1ns/1ns
module test_io_line_mux_controller;
  import io_mux_pkg::*;
  logic          pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 0, ext_val = 32'hFFFF_FFFF, prdata, periph_in, pad_in;
  logic [31:0]   rd, oe, d, m, md, v, p;
  logic          pready, pslverr, fast_irq_input, ext_irq_input_0, ext_irq_input_1, irq;
  logic [3:0]    analog_sel;
  periph_drive_t periph_a = '0, periph_b = '0;
  pad_drive_t    pad;
  int            n_errors = 0, checks = 0, seed = 11676;
  always #25 pclk = ~pclk;
  io_line_mux_controller io_line_mux_controller_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .periph_a(periph_a),
    .periph_b(periph_b), .periph_in(periph_in), .fast_irq_input(fast_irq_input),
    .ext_irq_input_0(ext_irq_input_0), .ext_irq_input_1(ext_irq_input_1),
    .analog_sel(analog_sel), .pad_in(pad_in), .pad(pad), .irq(irq));
  board_model board_model_inst (.pad(pad), .pad_in(pad_in), .ext_val(ext_val));
  task automatic results();
    if (n_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] wd);
    int i;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  function automatic logic [31:0] pin_exp(logic [31:0] oe, d, md, x);
    return (oe & ~(md & d) & d) | (~(oe & ~(md & d)) & x);
  endfunction
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, OFF_FUNC_STAT, 0);
    chk("func_stat", RST_ALL_ONES, rd);
    apb(0, OFF_PU_STAT, 0);
    chk("pu_stat", RST_ZERO, rd);
    apb(0, 8'hFC, 0);
    chk("slverr", 1, {31'h0, err});
    apb(1, OFF_PU_DIS, 32'h001E_0000);
    apb(0, OFF_PU_STAT, 0);
    chk("pu_dis", 32'h001E_0000, rd);
    chk("pad_pu", ~32'h001E_0000, pad.pu);
    chk("analog_sel", 4'hF, analog_sel);
    apb(1, OFF_PU_EN, 32'h001E_0000);
    for (int k = 0; k < 8; k++) begin
      {oe, m, d, md, v} = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
      ext_val <= $random(seed);
      apb(1, OFF_OUT_EN, oe);
      apb(1, OFF_OUT_DIS, m | ~oe);
      oe = oe & ~m;
      apb(1, OFF_SET_DATA, d);
      apb(1, OFF_CLR_DATA, ~d);
      apb(1, OFF_SYNC_EN, m);
      apb(1, OFF_SYNC_DIS, ~m);
      apb(1, OFF_SYNC_DATA, v);
      d = (d & ~m) | (v & m);
      apb(1, OFF_MD_EN, md);
      apb(1, OFF_MD_DIS, ~md);
      apb(1, k[0] ? OFF_FILT_EN : OFF_FILT_DIS, m);
      apb(0, OFF_OUT_STAT, 0);
      chk("out_stat", oe, rd);
      chk("pad_oe", oe & ~(md & d), pad.oe);
      chk("pad_o", d & ~md, pad.o);
      repeat (6) @(posedge pclk);
      apb(0, OFF_PIN_STAT, 0);
      chk("pin_stat", pin_exp(oe, d, md, ext_val), rd);
    end
    apb(1, OFF_OUT_DIS, RST_ALL_ONES);
    repeat (6) @(posedge pclk);
    apb(0, OFF_IRQ_STAT, 0);
    apb(1, OFF_IRQ_EN, 32'h20);
    @(posedge pclk);
    chk("irq_idle", 0, {31'h0, irq});
    ext_val <= ext_val ^ 32'h20;
    repeat (6) @(posedge pclk);
    chk("irq_set", 1, {31'h0, irq});
    apb(0, OFF_IRQ_STAT, 0);
    chk("irq_stat", 32'h20, rd & 32'h20);
    repeat (2) @(posedge pclk);
    chk("irq_clr", 0, {31'h0, irq});
    apb(1, OFF_IRQ_DIS, 32'h20);
    ext_val <= RST_ALL_ONES ^ (ext_val & 32'h20);
    repeat (6) @(posedge pclk);
    chk("irq_mask", 0, {31'h0, irq});
    apb(0, OFF_IRQ_STAT, 0);
    chk("irq_latch", 32'h20, rd & 32'h20);
    m = m | 32'h80000;
    periph_a <= {d, RST_ALL_ONES};
    periph_b <= {~d, ~m};
    apb(1, OFF_MD_DIS, RST_ALL_ONES);
    apb(1, OFF_SEL_B, m);
    apb(1, OFF_SEL_A, ~m);
    apb(1, OFF_FUNC_DIS, RST_ALL_ONES);
    repeat (6) @(posedge pclk);
    p = pin_exp(~m, d, 0, ext_val);
    chk("pad_func", (d & ~m) | (~d & m), pad.o);
    chk("pad_oe_b", ~m, pad.oe);
    chk("periph_in", p, periph_in);
    chk("fast_irq", {31'h0, m[19] & p[19]}, {31'h0, fast_irq_input});
    chk("irq_in_0", {31'h0, m[20] & p[20]}, {31'h0, ext_irq_input_0});
    chk("irq_in_1", {31'h0, ~m[30] & p[30]}, {31'h0, ext_irq_input_1});
    chk("analog_off", 0, {28'h0, analog_sel});
    results();
  end
endmodule // test_io_line_mux_controller
